// File: hw/lpwm_pkg.sv
// Constants for the four-channel LED PWM driver bank
package lpwm_pkg;
    localparam int CHANNELS = 4;
    localparam int RATE_W = 3;
    localparam int DUTY_W = 4;
    // Timebase clock
    localparam longint CLK_HZ = 20000000;
    // Sixteen duty slots per period; slot length in cycles = CLK_HZ*4/(16*rate_x4)
    localparam int SLOTS = 16;
    localparam int SLOT_W = 4;
    localparam int CNT_W = 23;
    // Rates stored times four so that 0.25 Hz is a whole number
    localparam longint RATE_X4_0 = 1;
    localparam longint RATE_X4_1 = 2;
    localparam longint RATE_X4_2 = 4;
    localparam longint RATE_X4_3 = 8;
    localparam longint RATE_X4_4 = 512;
    localparam longint RATE_X4_5 = 1024;
    localparam int RATE_SCALE = 4;
    localparam logic [RATE_W-1:0] RATE_CODE_0 = 3'h0;
    localparam logic [RATE_W-1:0] RATE_CODE_1 = 3'h1;
    localparam logic [RATE_W-1:0] RATE_CODE_2 = 3'h2;
    localparam logic [RATE_W-1:0] RATE_CODE_3 = 3'h3;
    localparam logic [RATE_W-1:0] RATE_CODE_4 = 3'h4;
    localparam logic [RATE_W-1:0] RATE_CODE_5 = 3'h5;
    localparam logic [RATE_W-1:0] RATE_RES_A = 3'h6;
    localparam logic [RATE_W-1:0] RATE_RES_B = 3'h7;
    localparam logic [DUTY_W-1:0] DUTY_FULL = 4'hF;
    localparam logic [CNT_W-1:0] CNT_ZERO = 23'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 23'h000001;
    localparam logic [SLOT_W-1:0] SLOT_ZERO = 4'h0;
    localparam logic [SLOT_W-1:0] SLOT_ONE = 4'h1;
endpackage

// File: hw/lpwm_driver_bank.sv
// Four independent PWM LED driver channels with rate and duty codes
`timescale 1ns/1ns
module lpwm_driver_bank
    import lpwm_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [CHANNELS-1:0] pwm_channel_enable,
    input wire logic [CHANNELS*RATE_W-1:0] pwm_rate_code,
    input wire logic [CHANNELS*DUTY_W-1:0] pwm_duty_code,
    output logic [CHANNELS-1:0] ledOut
);
    typedef enum logic [1:0] {
        CH_OFF = 2'b00,
        CH_HOLD = 2'b01,
        CH_START = 2'b10,
        CH_RUN = 2'b11
    } lpwm_state_e;

    // Integer division leaves the two fast rates a fraction of a percent fast
    localparam logic [CNT_W-1:0] SLOT_CYC_0 = CNT_W'(CLK_HZ * RATE_SCALE / (SLOTS * RATE_X4_0));
    localparam logic [CNT_W-1:0] SLOT_CYC_1 = CNT_W'(CLK_HZ * RATE_SCALE / (SLOTS * RATE_X4_1));
    localparam logic [CNT_W-1:0] SLOT_CYC_2 = CNT_W'(CLK_HZ * RATE_SCALE / (SLOTS * RATE_X4_2));
    localparam logic [CNT_W-1:0] SLOT_CYC_3 = CNT_W'(CLK_HZ * RATE_SCALE / (SLOTS * RATE_X4_3));
    localparam logic [CNT_W-1:0] SLOT_CYC_4 = CNT_W'(CLK_HZ * RATE_SCALE / (SLOTS * RATE_X4_4));
    localparam logic [CNT_W-1:0] SLOT_CYC_5 = CNT_W'(CLK_HZ * RATE_SCALE / (SLOTS * RATE_X4_5));

    // One independent slice per pin
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : gChan
            logic [RATE_W-1:0] rate;
            logic [DUTY_W-1:0] duty;
            logic enabled;
            logic reserved;
            logic rateSame;

            logic [CNT_W-1:0] slotLen;
            logic lastCyc;
            logic active;
            logic lit;

            lpwm_state_e state_reg;
            lpwm_state_e state_next;
            logic [RATE_W-1:0] rateSeen_reg;

            logic [CNT_W-1:0] cycCnt_reg;
            logic [CNT_W-1:0] cycCnt_next;
            logic [SLOT_W-1:0] slot_reg;
            logic [SLOT_W-1:0] slot_next;

            logic outBit_next;
            logic outBit_reg;

            // Each channel reads only its own slice of the settings
            assign rate = pwm_rate_code[ch*RATE_W +: RATE_W];
            assign duty = pwm_duty_code[ch*DUTY_W +: DUTY_W];
            assign enabled = pwm_channel_enable[ch];
            assign reserved = (rate == RATE_RES_A) || (rate == RATE_RES_B);
            assign rateSame = (rate == rateSeen_reg);

            always_comb begin
                unique case (rate)
                    RATE_CODE_0: begin
                        slotLen = SLOT_CYC_0;
                    end
                    RATE_CODE_1: begin
                        slotLen = SLOT_CYC_1;
                    end
                    RATE_CODE_2: begin
                        slotLen = SLOT_CYC_2;
                    end
                    RATE_CODE_3: begin
                        slotLen = SLOT_CYC_3;
                    end
                    RATE_CODE_4: begin
                        slotLen = SLOT_CYC_4;
                    end
                    RATE_CODE_5: begin
                        slotLen = SLOT_CYC_5;
                    end
                    default: begin
                        slotLen = SLOT_CYC_0;
                    end
                endcase
            end

            assign lastCyc = (cycCnt_reg >= slotLen - CNT_ONE);

            // Enable, leaving a reserved code and a rate change all open a fresh period
            always_comb begin
                unique case (state_reg)
                    CH_OFF: begin
                        if (!enabled) begin
                            state_next = CH_OFF;
                        end else if (reserved) begin
                            state_next = CH_HOLD;
                        end else begin
                            state_next = CH_START;
                        end
                    end
                    CH_HOLD: begin
                        if (!enabled) begin
                            state_next = CH_OFF;
                        end else if (reserved) begin
                            state_next = CH_HOLD;
                        end else begin
                            state_next = CH_START;
                        end
                    end
                    CH_START: begin
                        if (!enabled) begin
                            state_next = CH_OFF;
                        end else if (reserved) begin
                            state_next = CH_HOLD;
                        end else if (rateSame) begin
                            state_next = CH_RUN;
                        end else begin
                            state_next = CH_START;
                        end
                    end
                    CH_RUN: begin
                        if (!enabled) begin
                            state_next = CH_OFF;
                        end else if (reserved) begin
                            state_next = CH_HOLD;
                        end else if (rateSame) begin
                            state_next = CH_RUN;
                        end else begin
                            state_next = CH_START;
                        end
                    end
                endcase
            end

            assign active = (state_next == CH_START) || (state_next == CH_RUN);

            // Cycle counter within the current slot
            always_comb begin
                cycCnt_next = CNT_ZERO;
                if (state_next == CH_RUN) begin
                    if (lastCyc) begin
                        cycCnt_next = CNT_ZERO;
                    end else begin
                        cycCnt_next = cycCnt_reg + CNT_ONE;
                    end
                end
            end

            // Slot index within the period
            always_comb begin
                slot_next = SLOT_ZERO;
                if (state_next == CH_RUN) begin
                    if (lastCyc) begin
                        slot_next = slot_reg + SLOT_ONE;
                    end else begin
                        slot_next = slot_reg;
                    end
                end
            end

            // Output follows the slot being entered, so each slot lasts exactly its length
            // Slots 0..duty are on, so on-time is (duty+1)/16; 1111 is always on
            assign lit = (duty == DUTY_FULL) || (slot_next <= duty);

            always_comb begin
                outBit_next = 1'b0;
                if (active) begin
                    outBit_next = lit;
                end
            end

            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    state_reg <= CH_OFF;
                end else begin
                    state_reg <= state_next;
                end
            end

            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    rateSeen_reg <= RATE_CODE_0;
                end else begin
                    rateSeen_reg <= rate;
                end
            end

            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    cycCnt_reg <= CNT_ZERO;
                end else begin
                    cycCnt_reg <= cycCnt_next;
                end
            end

            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    slot_reg <= SLOT_ZERO;
                end else begin
                    slot_reg <= slot_next;
                end
            end

            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    outBit_reg <= 1'b0;
                end else begin
                    outBit_reg <= outBit_next;
                end
            end

            assign ledOut[ch] = outBit_reg;
        end
    endgenerate
endmodule

// File: test/lpwm_properties.sv
// Port checker for the LED PWM bank
`timescale 1ns/1ns
module lpwm_properties
    import lpwm_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [CHANNELS-1:0] pwm_channel_enable,
    input wire logic [CHANNELS*RATE_W-1:0] pwm_rate_code,
    input wire logic [CHANNELS*DUTY_W-1:0] pwm_duty_code,
    input wire logic [CHANNELS-1:0] ledOut
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence s_go0; $rose(pwm_channel_enable[0]) && pwm_rate_code[2:1] != 2'h3; endsequence
    sequence s_go1; $rose(pwm_channel_enable[1]) && pwm_rate_code[5:4] != 2'h3; endsequence
    a_off_dark: assert property (1 |=> (ledOut & ~$past(pwm_channel_enable)) == 4'h0)
        else $error("disabled LED lit");
    a_rsv_dark0: assert property (pwm_rate_code[2:1] == 2'h3 |=> !ledOut[0])
        else $error("reserved rate lit LED 0");
    a_rsv_dark3: assert property (pwm_rate_code[11:10] == 2'h3 |=> !ledOut[3])
        else $error("reserved rate lit LED 3");
    a_start_lit0: assert property (s_go0 |-> ##[1:3] ledOut[0])
        else $error("LED 0 not lit after enable");
    a_start_lit1: assert property (s_go1 |-> ##[1:3] ledOut[1])
        else $error("LED 1 not lit after enable");
    a_full_duty: assert property ((pwm_channel_enable[2] && pwm_duty_code[11:8] == 4'hF
        && pwm_rate_code[8:7] != 2'h3)[*3] |-> ledOut[2])
        else $error("full duty LED dark");
endmodule
bind lpwm_driver_bank lpwm_properties lpwm_properties_i(.core_clk(core_clk), .nrst(nrst),
    .pwm_channel_enable(pwm_channel_enable), .pwm_rate_code(pwm_rate_code),
    .pwm_duty_code(pwm_duty_code), .ledOut(ledOut));

// File: test/lpwm_led_model.sv
// LED load model that measures each LED's lit run
`timescale 1ns/1ns
module lpwm_led_model
    import lpwm_pkg::*;
(
    input wire logic core_clk,
    input wire logic [CHANNELS-1:0] ledOut,
    output int litRun [CHANNELS]
);
    int cnt [CHANNELS];
    always @(posedge core_clk) begin
        for (int i = 0; i < CHANNELS; i++) begin
            cnt[i] <= ledOut[i] ? cnt[i] + 1 : 0;
            if (!ledOut[i] && cnt[i] != 0) litRun[i] <= cnt[i];
        end
    end
endmodule

// File: test/testbench.sv
// Bench for the LED PWM bank
`timescale 1ns/1ns
module testbench;
    import lpwm_pkg::*;
    logic core_clk = 0;
    logic nrst = 0;
    logic [3:0] en = 0;
    logic [11:0] rate = 0;
    logic [15:0] duty = 0;
    logic [3:0] ledOut;
    int litRun [CHANNELS];
    int failures = 0;
    int checked = 0;
    lpwm_driver_bank lpwm_driver_bank_i(.core_clk(core_clk), .nrst(nrst),
        .pwm_channel_enable(en), .pwm_rate_code(rate), .pwm_duty_code(duty), .ledOut(ledOut));
    lpwm_led_model lpwm_led_model_i(.core_clk(core_clk), .ledOut(ledOut), .litRun(litRun));
    initial forever #25 core_clk = ~core_clk;
    task chk(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s exp %0d got %0d", n, e, g);
        end
    endtask
    task results;
        if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task mixed_rates;
        @(posedge core_clk);
        en <= 4'hF;
        rate <= 12'hD65;
        duty <= 16'h0F00;
        for (int i = 0; i < 12000 && litRun[1] == 0; i++) @(posedge core_clk);
        @(negedge core_clk);
        chk("run0", 4882, litRun[0]);
        chk("run1", 9765, litRun[1]);
        chk("led2", 1, ledOut[2]);
        chk("led3", 0, ledOut[3]);
    endtask
    task slow_rate;
        @(posedge core_clk);
        rate[2:0] <= 3'h3;
        repeat (6000) @(posedge core_clk);
        @(negedge core_clk);
        chk("slow0", 1, ledOut[0]);
    endtask
    task refuse_and_stop;
        @(posedge core_clk);
        rate <= 12'hF66;
        en[2] <= 1'b0;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk("led32", 0, ledOut[3:2]);
        chk("led0", 0, ledOut[0]);
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        mixed_rates();
        slow_rate();
        refuse_and_stop();
        results();
    end
endmodule
